// [hdl/pcs_mgmt_regs.v]
// Function
// - extended status bit 15 is read-only and reads 1 (1000BASE-X full duplex supported).
// - extended status bit 14 is read-only and reads 0 (1000BASE-X half duplex not supported).
// - extended status bit 13 is read-only and reads 1 (1000BASE-T full duplex supported).
// - extended status bit 12 is read-only and reads 0, and bits 11 to 0 are reserved.
// - jitter enable bit 15 replaces normal traffic with the selected test pattern, clear resumes, reset 0.
// - bits 14 to 12 are a read-write pattern selector that resets to 0.
// - selector 000 sends the custom pattern, 100 a random pattern, 110 and 111 are reserved.
// - selector 001 sends the alternating one-zero high-frequency pattern.
// - selector 010 repeats the twenty-bit mixed-frequency pattern.
// - selectors 011 and 101 repeat five ones then five zeros.
// - bits 9 to 0 hold the read-write custom pattern reset to 0, bits 11 and 10 reserved.
// - soft reset bit 15 of the link control register holds the functional logic in reset, reset 0.
// - with the fast timer bit 14 set both link-go and sync-fail timers expire after 64 clocks.
// - with it clear link-go counts 200000 and sync-fail 1250000 clocks.
// - bit 13 of the link control register is a read-write receive disparity disable, reset 0.
// - the receive disparity disable stops disparity calculation and checking on received data.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "pcs_consts.vh"

module pcs_mgmt_regs #(
  parameter AW          = 8,
  parameter LINK_TICKS  = `PCS_LINK_GO_TICKS,
  parameter SYNC_TICKS  = `PCS_SYNC_FAIL_TICKS,
  parameter TW          = 21
) (
  input  wire          clk_sys,
  input  wire          nrst,
  // axi4-lite slave
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // transmit path
  input  wire [9:0]    txNormalCode,
  output reg  [9:0]    txCode,
  output reg           jitterActive,
  // pcs control
  input  wire          linkGoStart,
  input  wire          syncFailStart,
  output reg           linkGoExpired,
  output reg           syncFailExpired,
  output reg           funcResetN,
  output reg           rxDisparityOff
);

  // ****************************************
  // reset synchroniser
  // ****************************************
  reg rstMeta_q;
  reg rstN_q;

  // two-stage release of the async reset
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // ****************************************
  // helper functions
  // ****************************************
  // merge byte lanes of a write into a 16-bit register under a mask
  function [15:0] mergeWrite;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    input [15:0] mask;
    reg   [15:0] tmp;
    begin
      tmp = old;
      if (strb[0])
        tmp[7:0] = data[7:0];
      if (strb[1])
        tmp[15:8] = data[15:8];
      mergeWrite = tmp & mask;
    end
  endfunction

  // advance a 15-bit prbs by ten steps
  function [14:0] lfsrStep10;
    input [14:0] s;
    reg   [14:0] t;
    integer      i;
    begin
      t = s;
      for (i = 0; i < 10; i = i + 1)
        t = {t[13:0], t[14] ^ t[13]};
      lfsrStep10 = t;
    end
  endfunction

  // ****************************************
  // register state
  // ****************************************
  reg [15:0] jitterCtrl_q;
  reg [15:0] linkCtrl_q;
  wire       diagEn     = jitterCtrl_q[`PCS_JIT_EN_BIT];
  wire [2:0] patSel     = jitterCtrl_q[`PCS_JIT_SEL_HI:`PCS_JIT_SEL_LO];
  wire [9:0] customPat  = jitterCtrl_q[`PCS_JIT_PAT_HI:`PCS_JIT_PAT_LO];
  wire       softReset  = linkCtrl_q[`PCS_LNK_SRST_BIT];
  wire       fastTimer  = linkCtrl_q[`PCS_LNK_FAST_BIT];
  wire       rxRdDisable = linkCtrl_q[`PCS_LNK_RXRD_BIT];

  // ****************************************
  // axi write channel
  // ****************************************
  reg [AW-1:0] wrAddr_q;
  reg [31:0]   wrData_q;
  reg [3:0]    wrStrb_q;
  reg          haveAw_q;
  reg          haveW_q;
  wire         awTake  = s_axi_awvalid & s_axi_awready;
  wire         wTake   = s_axi_wvalid & s_axi_wready;
  wire         awNow   = haveAw_q | awTake;
  wire         wNow    = haveW_q | wTake;
  wire [AW-1:0] awSel  = haveAw_q ? wrAddr_q : s_axi_awaddr;
  wire [31:0]  wSel    = haveW_q ? wrData_q : s_axi_wdata;
  wire [3:0]   sSel    = haveW_q ? wrStrb_q : s_axi_wstrb;
  wire         doWrite = awNow & wNow & ~s_axi_bvalid;

  // accept address and data in either order, answer once both held
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCS_RESP_OKAY;
      haveAw_q      <= 1'b0;
      haveW_q       <= 1'b0;
      wrAddr_q      <= {AW{1'b0}};
      wrData_q      <= 32'h00000000;
      wrStrb_q      <= 4'h0;
    end else begin
      if (awTake) begin
        wrAddr_q <= s_axi_awaddr;
        haveAw_q <= 1'b1;
      end
      if (wTake) begin
        wrData_q <= s_axi_wdata;
        wrStrb_q <= s_axi_wstrb;
        haveW_q  <= 1'b1;
      end
      if (doWrite) begin
        haveAw_q     <= 1'b0;
        haveW_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awSel == `PCS_ADDR_JITTER_CTRL || awSel == `PCS_ADDR_LINK_CTRL ||
                         awSel == `PCS_ADDR_EXT_STATUS) ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // ready only while nothing of that kind is held or answered
      s_axi_awready <= ~(awNow & ~doWrite) & ~(s_axi_bvalid & ~s_axi_bready) & ~doWrite & ~s_axi_awready;
      s_axi_wready  <= ~(wNow & ~doWrite) & ~(s_axi_bvalid & ~s_axi_bready) & ~doWrite & ~s_axi_wready;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // status register takes no writes, reserved bits masked off
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      jitterCtrl_q <= `PCS_JIT_RESET;
      linkCtrl_q   <= `PCS_LNK_RESET;
    end else if (doWrite) begin
      if (awSel == `PCS_ADDR_JITTER_CTRL)
        jitterCtrl_q <= mergeWrite(jitterCtrl_q, wSel, sSel, `PCS_JIT_WMASK);
      if (awSel == `PCS_ADDR_LINK_CTRL)
        linkCtrl_q <= mergeWrite(linkCtrl_q, wSel, sSel, `PCS_LNK_WMASK);
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  reg [15:0] rdWord;
  reg        rdHit;

  // read decode, upper half reads zero
  always @* begin
    rdHit  = 1'b1;
    rdWord = 16'h0000;
    case (s_axi_araddr)
      `PCS_ADDR_EXT_STATUS:  rdWord = `PCS_EXT_STATUS_VAL;
      `PCS_ADDR_JITTER_CTRL: rdWord = jitterCtrl_q;
      `PCS_ADDR_LINK_CTRL:   rdWord = linkCtrl_q;
      default: rdHit = 1'b0;
    endcase
  end

  // one read under way; data registered with the answer
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PCS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rdWord};
        s_axi_rresp   <= rdHit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // jitter pattern generator
  // ****************************************
  reg        phase_q;
  reg [14:0] lfsr_q;
  reg [9:0]  patCode;
  reg        patValid;

  // second half flag for twenty-bit patterns, prbs for random
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      phase_q <= 1'b0;
      lfsr_q  <= `PCS_LFSR_SEED;
    end else if (softReset || !diagEn) begin
      phase_q <= 1'b0;
      lfsr_q  <= `PCS_LFSR_SEED;
    end else begin
      phase_q <= ~phase_q;
      lfsr_q  <= lfsrStep10(lfsr_q);
    end
  end

  // symbol chosen by the selector
  always @* begin
    patValid = 1'b1;
    case (patSel)
      `PCS_SEL_CUSTOM:     patCode = customPat;
      `PCS_SEL_HIGH:       patCode = `PCS_SYM_HIGH;
      `PCS_SEL_MIXED:      patCode = phase_q ? `PCS_SYM_MIXED_B : `PCS_SYM_MIXED_A;
      `PCS_SEL_LOW_CUSTOM: patCode = `PCS_SYM_LOW;
      `PCS_SEL_RANDOM:     patCode = lfsr_q[9:0];
      `PCS_SEL_LOW_STD:    patCode = `PCS_SYM_LOW;
      default: begin
        patCode  = 10'h000; // reserved codes fall back to traffic
        patValid = 1'b0;
      end
    endcase
  end

  // transmit mux: pattern replaces traffic while enabled
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      txCode       <= 10'h000;
      jitterActive <= 1'b0;
    end else if (softReset) begin
      txCode       <= 10'h000;
      jitterActive <= 1'b0;
    end else begin
      jitterActive <= diagEn & patValid;
      txCode       <= (diagEn && patValid) ? patCode : txNormalCode;
    end
  end

  // ****************************************
  // link timers
  // ****************************************
  wire linkExp;
  wire syncExp;

  // link-go timer, held while soft reset is set
  pcs_tick_timer #(
    .W          (TW),
    .FAST_TICKS (`PCS_FAST_TICKS),
    .SLOW_TICKS (LINK_TICKS)
  ) uLinkTimer (
    .clk_sys (clk_sys),
    .rstN    (rstN_q),
    .hold    (softReset),
    .restart (linkGoStart),
    .fastSel (fastTimer),
    .expired (linkExp)
  );

  // sync-status-fail timer
  pcs_tick_timer #(
    .W          (TW),
    .FAST_TICKS (`PCS_FAST_TICKS),
    .SLOW_TICKS (SYNC_TICKS)
  ) uSyncTimer (
    .clk_sys (clk_sys),
    .rstN    (rstN_q),
    .hold    (softReset),
    .restart (syncFailStart),
    .fastSel (fastTimer),
    .expired (syncExp)
  );

  // ****************************************
  // control outputs
  // ****************************************
  // registered copies of control for the rest of the pcs
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      funcResetN      <= 1'b0;
      rxDisparityOff  <= 1'b0;
      linkGoExpired   <= 1'b0;
      syncFailExpired <= 1'b0;
    end else begin
      funcResetN      <= ~softReset;
      rxDisparityOff  <= rxRdDisable;
      linkGoExpired   <= linkExp;
      syncFailExpired <= syncExp;
    end
  end

endmodule

// [hdl/pcs_consts.vh]
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define PCS_IDX_EXT_STATUS   8'h0F
`define PCS_IDX_JITTER_CTRL  8'h10
`define PCS_IDX_LINK_CTRL    8'h11
`define PCS_ADDR_EXT_STATUS  8'h3C
`define PCS_ADDR_JITTER_CTRL 8'h40
`define PCS_ADDR_LINK_CTRL   8'h44

// ****************************************
// extended status fields and values
// ****************************************
`define PCS_EXT_X_FD_BIT     15
`define PCS_EXT_X_HD_BIT     14
`define PCS_EXT_T_FD_BIT     13
`define PCS_EXT_T_HD_BIT     12
`define PCS_EXT_STATUS_VAL   16'hA000

// ****************************************
// jitter control fields
// ****************************************
`define PCS_JIT_EN_BIT       15
`define PCS_JIT_SEL_HI       14
`define PCS_JIT_SEL_LO       12
`define PCS_JIT_PAT_HI       9
`define PCS_JIT_PAT_LO       0
`define PCS_JIT_WMASK        16'hF3FF
`define PCS_JIT_RESET        16'h0000

// ****************************************
// pattern selector codes and symbols
// ****************************************
`define PCS_SEL_CUSTOM       3'h0
`define PCS_SEL_HIGH         3'h1
`define PCS_SEL_MIXED        3'h2
`define PCS_SEL_LOW_CUSTOM   3'h3
`define PCS_SEL_RANDOM       3'h4
`define PCS_SEL_LOW_STD      3'h5
`define PCS_SYM_HIGH         10'h2AA
`define PCS_SYM_MIXED_A      10'h3EB
`define PCS_SYM_MIXED_B      10'h014
`define PCS_SYM_LOW          10'h3E0
`define PCS_LFSR_SEED        15'h7FFF

// ****************************************
// link control fields
// ****************************************
`define PCS_LNK_SRST_BIT     15
`define PCS_LNK_FAST_BIT     14
`define PCS_LNK_RXRD_BIT     13
`define PCS_LNK_WMASK        16'hE000
`define PCS_LNK_RESET        16'h0000

// ****************************************
// timer counts in clock pulses
// ****************************************
`define PCS_FAST_TICKS       64
`define PCS_LINK_GO_TICKS    200000
`define PCS_SYNC_FAIL_TICKS  1250000

// ****************************************
// bus answers
// ****************************************
`define PCS_RESP_OKAY        2'h0
`define PCS_RESP_SLVERR      2'h2

`endif

// [hdl/pcs_tick_timer.v]
`timescale 1ns/10ps
// ****************************************
// restartable down-counter with one-cycle expiry pulse
// ****************************************
module pcs_tick_timer #(
  parameter W         = 21,
  parameter FAST_TICKS = 64,
  parameter SLOW_TICKS = 200000
) (
  input  wire         clk_sys,
  input  wire         rstN,
  input  wire         hold,
  input  wire         restart,
  input  wire         fastSel,
  output reg          expired
);

  reg [W-1:0] cnt_q;
  reg         running_q;

  // load on restart, count down, pulse at zero
  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      cnt_q     <= {W{1'b0}};
      running_q <= 1'b0;
      expired   <= 1'b0;
    end else if (hold) begin
      cnt_q     <= {W{1'b0}};
      running_q <= 1'b0;
      expired   <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (restart) begin
        cnt_q     <= fastSel ? FAST_TICKS[W-1:0] - {{(W-1){1'b0}}, 1'b1}
                             : SLOW_TICKS[W-1:0] - {{(W-1){1'b0}}, 1'b1};
        running_q <= 1'b1;
      end else if (running_q) begin
        if (cnt_q == {W{1'b0}}) begin
          expired   <= 1'b1;
          running_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// [verif/pcs_mgmt_regs_assertions.sv]
`timescale 1ns/10ps
`include "pcs_consts.vh"
module pcs_mgmt_regs_assertions #(
  parameter AW = 8
) (
  input wire          clk_sys,
  input wire          nrst,
  input wire [AW-1:0] s_axi_araddr,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire [31:0]   s_axi_rdata,
  input wire [1:0]    s_axi_rresp,
  input wire          s_axi_rvalid,
  input wire          s_axi_rready,
  input wire [1:0]    s_axi_bresp,
  input wire          s_axi_bvalid,
  input wire          s_axi_bready,
  input wire [9:0]    txNormalCode,
  input wire [9:0]    txCode,
  input wire          jitterActive,
  input wire          funcResetN,
  input wire          linkGoExpired
);
  reg  [AW-1:0] rdA_q;
  wire          known;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // address of the read under way
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdA_q <= {AW{1'b0}};
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdA_q <= s_axi_araddr;
    end
  end
  assign known = rdA_q == `PCS_ADDR_EXT_STATUS || rdA_q == `PCS_ADDR_JITTER_CTRL || rdA_q == `PCS_ADDR_LINK_CTRL;
  // ****************************************
  // read data, hold, transmit and expiry pulse checks
  // ****************************************
  a_status_value: assert property (s_axi_rvalid && rdA_q == `PCS_ADDR_EXT_STATUS |->
    s_axi_rdata == 32'h0000A000 && s_axi_rresp == `PCS_RESP_OKAY) else $error("status read wrong");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  a_jit_resv: assert property (s_axi_rvalid && rdA_q == `PCS_ADDR_JITTER_CTRL |->
    s_axi_rdata[11:10] == 2'h0) else $error("jitter reserved bits set");
  a_link_resv: assert property (s_axi_rvalid && rdA_q == `PCS_ADDR_LINK_CTRL |->
    s_axi_rdata[12:0] == 13'h0000) else $error("link reserved bits set");
  a_unmapped_err: assert property (s_axi_rvalid && !known |->
    s_axi_rresp == `PCS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_tx_normal: assert property ((funcResetN && !jitterActive) [*3] |-> txCode == $past(txNormalCode))
    else $error("normal traffic not passed");
  a_srst_tx: assert property ((!funcResetN) [*2] |-> txCode == 10'h000) else $error("tx active in reset");
  a_expiry_pulse: assert property (linkGoExpired |=> !linkGoExpired) else $error("expiry not a pulse");
endmodule

// [verif/pcs_ext_status_jitter_test_regs_tb_top.sv]
`timescale 1ns/10ps
`include "pcs_consts.vh"
module pcs_ext_status_jitter_test_regs_tb_top;
  logic        clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  txNormalCode, txCode, t1;
  logic        jitterActive, linkGoStart, syncFailStart, linkGoExpired, syncFailExpired;
  logic        funcResetN, rxDisparityOff;
  int          n_fail, checks_done, k, lag;
  logic [2:0]  selTab [3] = '{3'h1, 3'h3, 3'h5};
  logic [9:0]  symTab [3] = '{10'h2AA, 10'h3E0, 10'h3E0};
  // short timer counts keep the run brief
  pcs_mgmt_regs #(.LINK_TICKS(100), .SYNC_TICKS(200)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .txNormalCode(txNormalCode), .txCode(txCode), .jitterActive(jitterActive),
    .linkGoStart(linkGoStart), .syncFailStart(syncFailStart), .linkGoExpired(linkGoExpired),
    .syncFailExpired(syncFailExpired), .funcResetN(funcResetN), .rxDisparityOff(rxDisparityOff)
  );
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // compare, report and bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic guard(input int i);
    if (i >= 300) begin
      n_fail++;
      $display("MISMATCH t=%0t wait ran out", $time);
      final_report;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int i;
    bit aw, w;
    @(posedge clk_sys);
    aw = 0;
    w = 0;
    i = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (lag == 0);
    do begin
      @(posedge clk_sys);
      i++;
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w) && i < 300);
    guard(i);
    for (i = 0; i < 300 && s_axi_bvalid !== 1'b1; i++) @(posedge clk_sys);
    guard(i);
    // late bready: answer must stand until taken
    if (lag > 0) begin
      cyc(lag);
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
    end
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge clk_sys);
    i = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (lag == 0);
    do begin
      @(posedge clk_sys);
      i++;
    end while (s_axi_arready !== 1'b1 && i < 300);
    guard(i);
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 300 && s_axi_rvalid !== 1'b1; i++) @(posedge clk_sys);
    guard(i);
    // late rready: data must stand until taken
    if (lag > 0) begin
      cyc(lag);
      s_axi_rready <= 1'b1;
      @(posedge clk_sys);
    end
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask
  // start one timer and count cycles to its expiry
  task automatic tmr(input bit s, input int n);
    int c;
    @(posedge clk_sys);
    linkGoStart   <= !s;
    syncFailStart <= s;
    @(posedge clk_sys);
    linkGoStart   <= 1'b0;
    syncFailStart <= 1'b0;
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while ((s ? syncFailExpired : linkGoExpired) !== 1'b1 && c < 300);
    guard(c);
    check(c, n + 2);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {linkGoStart, syncFailStart, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb  = 4'h3;
    txNormalCode = 10'h17C;
    n_fail = 0;
    checks_done = 0;
    lag = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(8);
    check(funcResetN, 1'b1);
    check(jitterActive, 1'b0);
    check(txCode, 10'h17C);
    rd(`PCS_ADDR_EXT_STATUS, 32'h0000A000, `PCS_RESP_OKAY);
    rd(`PCS_ADDR_JITTER_CTRL, 32'h0, `PCS_RESP_OKAY);
    rd(`PCS_ADDR_LINK_CTRL, 32'h0, `PCS_RESP_OKAY);
    wr(`PCS_ADDR_EXT_STATUS, 16'hFFFF, `PCS_RESP_OKAY);
    rd(`PCS_ADDR_EXT_STATUS, 32'h0000A000, `PCS_RESP_OKAY);
    wr(8'h48, 16'hFFFF, `PCS_RESP_SLVERR);
    rd(8'h48, 32'h0, `PCS_RESP_SLVERR);
    lag = 3;
    wr(`PCS_ADDR_JITTER_CTRL, 16'hFFFF, `PCS_RESP_OKAY);
    rd(`PCS_ADDR_JITTER_CTRL, 32'h0000F3FF, `PCS_RESP_OKAY);
    lag = 0;
    wr(`PCS_ADDR_JITTER_CTRL, 16'h8155, `PCS_RESP_OKAY);
    cyc(2);
    check(txCode, 10'h155);
    check(jitterActive, 1'b1);
    for (k = 0; k < 3; k++) begin
      wr(`PCS_ADDR_JITTER_CTRL, {1'b1, selTab[k], 12'h000}, `PCS_RESP_OKAY);
      cyc(2);
      check(txCode, symTab[k]);
    end
    wr(`PCS_ADDR_JITTER_CTRL, 16'hA000, `PCS_RESP_OKAY);
    cyc(2);
    t1 = txCode;
    cyc(1);
    check(t1 ^ txCode, 10'h3FF);
    check(t1 == 10'h3EB || t1 == 10'h014, 1'b1);
    wr(`PCS_ADDR_JITTER_CTRL, 16'hC000, `PCS_RESP_OKAY);
    cyc(3);
    t1 = txCode;
    cyc(1);
    check(t1 != txCode, 1'b1);
    check(jitterActive, 1'b1);
    wr(`PCS_ADDR_JITTER_CTRL, 16'hE000, `PCS_RESP_OKAY);
    cyc(2);
    check(jitterActive, 1'b0);
    wr(`PCS_ADDR_JITTER_CTRL, 16'h0000, `PCS_RESP_OKAY);
    txNormalCode <= 10'h0F0;
    cyc(3);
    check(txCode, 10'h0F0);
    wr(`PCS_ADDR_LINK_CTRL, 16'h2000, `PCS_RESP_OKAY);
    cyc(2);
    check(rxDisparityOff, 1'b1);
    wr(`PCS_ADDR_LINK_CTRL, 16'hFFFF, `PCS_RESP_OKAY);
    rd(`PCS_ADDR_LINK_CTRL, 32'h0000E000, `PCS_RESP_OKAY);
    check(funcResetN, 1'b0);
    check(txCode, 10'h000);
    wr(`PCS_ADDR_LINK_CTRL, 16'h4000, `PCS_RESP_OKAY);
    cyc(2);
    check(funcResetN, 1'b1);
    check(rxDisparityOff, 1'b0);
    tmr(1'b0, 64);
    tmr(1'b1, 64);
    wr(`PCS_ADDR_LINK_CTRL, 16'h0000, `PCS_RESP_OKAY);
    tmr(1'b0, 100);
    tmr(1'b1, 200);
    final_report;
  end
endmodule
bind pcs_mgmt_regs pcs_mgmt_regs_assertions #(.AW(AW)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .txNormalCode(txNormalCode),
  .txCode(txCode), .jitterActive(jitterActive), .funcResetN(funcResetN), .linkGoExpired(linkGoExpired)
);
